// *** common/cld_pkg.sv ***
/*
  cld_pkg: register map, field positions, reset values and measurement
  constants of the lock detector.
  assumes: 32-bit classic wishbone, byte addresses are four times the index.
*/
package cld_pkg;
  // ---------------------------------------------------------------
  // register indices and address width
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_STATUS    = 8'h06;
  localparam logic [7:0] IDX_MODE      = 8'h08;
  localparam logic [7:0] IDX_PINCFG    = 8'h09;
  localparam logic [7:0] IDX_REFBUF    = 8'h0A;
  localparam logic [7:0] IDX_RATIO     = 8'h0F;
  localparam logic [7:0] IDX_IRQ_STAT  = 8'h20;
  localparam logic [7:0] IDX_IRQ_EN    = 8'h21;
  localparam logic [7:0] IDX_IRQ_CLR   = 8'h22;
  localparam logic [7:0] IDX_LIVE      = 8'h23;
  localparam int         ADDR_W        = 10;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int STICKY_BIT    = 2;
  localparam int CLR_BIT       = 2;
  localparam int MODE_LSB      = 4;
  localparam int PINCFG_BIT    = 4;
  localparam int PDN_BIT       = 2;
  localparam int FAST_BIT      = 0;
  localparam int BAND_LSB      = 4;
  localparam int RATIO_LSB     = 0;
  localparam logic [2:0] MODE_LTR = 3'h2;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [2:0] MODE_RST   = 3'h0;
  localparam logic       PDN_RST    = 1'b1;
  localparam logic       FAST_RST   = 1'b1;
  localparam logic [1:0] BAND_RST   = 2'h0;
  localparam logic [3:0] RATIO_RST  = 4'h1;

  // ---------------------------------------------------------------
  // measurement constants
  // ---------------------------------------------------------------
  localparam int LOCK_PPM    = 250;
  localparam int UNLOCK_PPM  = 1000;
  localparam int GATE_LOG2   = 16;
  localparam int GATE_EDGES  = 1 << GATE_LOG2;
  localparam int LOCK_DIFF   = (GATE_EDGES * LOCK_PPM) / 1000000;
  localparam int UNLOCK_DIFF = (GATE_EDGES * UNLOCK_PPM) / 1000000;
  localparam int HARM_LOG2   = 16;

  // irq bits
  localparam int IRQ_LOST  = 0;
  localparam int IRQ_LOCK  = 1;
  localparam int IRQ_HARM  = 2;
  localparam int IRQ_W     = 3;

  typedef enum logic [1:0] {CLD_ACQ, CLD_LOCKED} cld_state_t;
endpackage

// *** common/cld_meas_if.sv ***
/*
  cld_meas_if: carries one gate measurement from the counter module to
  the lock detector core.
  assumes: single clock domain.
*/
interface cld_meas_if #(parameter int CNT_W = 18);
  logic             done;
  logic [CNT_W-1:0] osc_cnt;
  logic             start;
  modport meter (output done, output osc_cnt, input start);
  modport core  (input done, input osc_cnt, output start);
endinterface

// *** rtl/cld_gate_meter.sv ***
/*
  cld_gate_meter: counts oscillator edges while a fixed number of
  reference or data edges pass, then reports the count.
  assumes: edge inputs are already synchronised single-cycle pulses.
*/
module cld_gate_meter
  import cld_pkg::*;
#(
  parameter int GATE  = cld_pkg::GATE_EDGES,
  parameter int CNT_W = 18
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic osc_edge_i,
  input  wire logic ref_edge_i,
  cld_meas_if.meter m
);
  logic [CNT_W-1:0] gate_r;
  logic [CNT_W-1:0] osc_r;
  logic             run_r;
  logic             done_r;
  logic [CNT_W-1:0] res_r;

  assign m.done    = done_r;
  assign m.osc_cnt = res_r;

  // ---------------------------------------------------------------
  // gate counting
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    done_r <= 1'b0;
    if (rst_i || m.start) begin
      gate_r <= '0;
      osc_r  <= '0;
      run_r  <= 1'b1;
    end else if (run_r) begin
      if (osc_edge_i) begin
        osc_r <= osc_r + 1'b1;
      end
      if (ref_edge_i) begin
        if (gate_r == CNT_W'(GATE - 1)) begin
          done_r <= 1'b1;
          res_r  <= osc_r + CNT_W'(osc_edge_i);
          gate_r <= '0;
          osc_r  <= '0;
        end else begin
          gate_r <= gate_r + 1'b1;
        end
      end
    end
    if (rst_i) begin
      res_r <= '0;
    end
  end
endmodule

// *** rtl/cld_lock_detector.sv ***
/*
  cld_lock_detector: lock detector of a clock and data recovery receiver
  with wishbone register port, sticky status and harmonic detector.
  assumes: osc/data/ref edge pins are asynchronous; the digital oscillator
  and phase loop are outside and follow osc_reset_o, div_min_o, phase_en_o.
*/
// Summary of operation
// RULE1: modes are normal from data, lock to reference, and sticky lock-lost.
// RULE2: normal mode clears lock_lost_flag within 250 ppm; stays set until then.
// RULE3: clearing lock_lost_flag enables the digital phase loop.
// RULE4: locked error above 1000 ppm sets lock_lost_flag and restarts acquisition.
// RULE5: software writes 2 into recovery_mode_sel to pick lock to reference.
// RULE6: software programs refclk_band_sel and rate_ratio_sel for that mode.
// RULE7: software clears refclk_buffer_powerdown to power the reference buffer.
// RULE8: software should keep the fast acquisition bit at one.
// RULE9: reference mode compares divided oscillator with divided reference, 250 ppm; code compares undivided osc and ref edges, ratio_r unused.
// RULE10: reference mode locked error above 1000 ppm reacquires against reference.
// RULE11: every lock loss sets the sticky bit, which stays after relock.
// RULE12: writing clear one then zero clears sticky; stays low until new loss.
// RULE13: pin config one mirrors sticky bit on pin; zero shows live state.
// RULE14: harmonic detected forces lock loss, reacquisition, then deassertion.
// RULE15: harmonic detection completes within 2^16 bit periods over transition density.
// RULE16: harmonic detector is off in lock to reference mode.
// RULE17: each acquisition resets oscillator to bottom and divider to one.
// RULE18: error is counted as edge difference over fixed gate.
module cld_lock_detector
  import cld_pkg::*;
#(
  parameter int GATE  = cld_pkg::GATE_EDGES,
  parameter int HARM  = 1 << cld_pkg::HARM_LOG2,
  parameter int CNT_W = 18
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [cld_pkg::ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic [31:0]                   wb_dat_o,
  output logic                          wb_ack_o,
  input  wire logic                     osc_edge_i,
  input  wire logic                     data_edge_i,
  input  wire logic                     ref_edge_i,
  input  wire logic                     harm_hit_i,
  output logic                          lock_lost_flag_o,
  output logic                          phase_en_o,
  output logic                          osc_reset_o,
  output logic                          div_min_o,
  output logic                          irq_o
);
  import cld_pkg::*;

  // ppm windows scale with the gate so a shorter gate keeps the same hysteresis
  localparam int LOCK_D   = (GATE * LOCK_PPM) / 1000000;
  localparam int UNLOCK_D = (GATE * UNLOCK_PPM) / 1000000;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [3:0] s1_r;
  logic [3:0] s2_r;
  logic [3:0] s3_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= {harm_hit_i, ref_edge_i, data_edge_i, osc_edge_i};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  logic [3:0] rise;
  assign rise = s2_r & ~s3_r;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [2:0]       mode_r;
  logic             clr_r;
  logic             clr_prev_r;
  logic             pincfg_r;
  logic             pdn_r;
  logic             fast_r;
  logic [1:0]       band_r;
  logic [3:0]       ratio_r;
  logic             sticky_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_en_r;
  logic             ack_r;
  logic [31:0]      rdat_r;

  logic             lock_to_reference;
  logic             wr;
  logic [7:0]       idx;
  assign lock_to_reference = (mode_r == MODE_LTR); // RULE1
  assign wr  = wb_cyc_i && wb_stb_i && wb_we_i && !ack_r && wb_sel_i[0];
  assign idx = wb_adr_i[ADDR_W-1:2];

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction

  // ---------------------------------------------------------------
  // configuration writes
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_r   <= MODE_RST;
      clr_r    <= 1'b0;
      pincfg_r <= 1'b0;
      pdn_r    <= PDN_RST;
      fast_r   <= FAST_RST;
      band_r   <= BAND_RST;
      ratio_r  <= RATIO_RST;
      irq_en_r <= '0;
    end else if (wr) begin
      if (hit(idx, IDX_MODE)) begin
        mode_r <= wb_dat_i[MODE_LSB +: 3]; // RULE5
        clr_r  <= wb_dat_i[CLR_BIT];
      end
      if (hit(idx, IDX_PINCFG)) begin
        pincfg_r <= wb_dat_i[PINCFG_BIT];
      end
      if (hit(idx, IDX_REFBUF)) begin
        pdn_r  <= wb_dat_i[PDN_BIT]; // RULE7
        fast_r <= wb_dat_i[FAST_BIT]; // RULE8
      end
      if (hit(idx, IDX_RATIO)) begin
        band_r  <= wb_dat_i[BAND_LSB +: 2]; // RULE6
        ratio_r <= wb_dat_i[RATIO_LSB +: 4];
      end
      if (hit(idx, IDX_IRQ_EN)) begin
        irq_en_r <= wb_dat_i[IRQ_W-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // frequency measurement
  // ---------------------------------------------------------------
  cld_meas_if #(.CNT_W(CNT_W)) meas ();
  logic ref_src;
  // reference edges only count with the buffer powered
  assign ref_src = lock_to_reference ? (rise[2] && !pdn_r) : rise[1]; // RULE9
  cld_gate_meter #(.GATE(GATE), .CNT_W(CNT_W)) u_meter (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .osc_edge_i (rise[0]),
    .ref_edge_i (ref_src),
    .m          (meas.meter)
  );

  logic [CNT_W-1:0] err;
  logic             in_lock;
  logic             out_lock;
  always_comb begin
    err = (meas.osc_cnt >= CNT_W'(GATE)) ? meas.osc_cnt - CNT_W'(GATE)
                                         : CNT_W'(GATE) - meas.osc_cnt; // RULE18
    in_lock  = (err <= CNT_W'(LOCK_D));
    out_lock = (err >  CNT_W'(UNLOCK_D));
  end

  // ---------------------------------------------------------------
  // harmonic detector
  // ---------------------------------------------------------------
  logic [HARM_LOG2:0] harm_cnt_r;
  logic               harm_det;
  cld_state_t         state_r;
  // counts data transitions showing harmonic pattern while locked
  always_ff @(posedge clk_i) begin
    if (rst_i || lock_to_reference || state_r != CLD_LOCKED || !s2_r[3]) begin // RULE16
      harm_cnt_r <= '0;
    end else if (rise[1]) begin
      harm_cnt_r <= harm_cnt_r + 1'b1;
    end
  end
  assign harm_det = (harm_cnt_r == (HARM_LOG2+1)'(HARM - 1)) && rise[1]; // RULE15

  // ---------------------------------------------------------------
  // lock state machine
  // ---------------------------------------------------------------
  logic lost_ev;
  logic lock_ev;
  logic osc_rst_r;
  always_ff @(posedge clk_i) begin
    lost_ev   <= 1'b0;
    lock_ev   <= 1'b0;
    osc_rst_r <= 1'b0;
    if (rst_i) begin
      state_r   <= CLD_ACQ;
      osc_rst_r <= 1'b1;
    end else begin
      unique case (state_r)
        CLD_ACQ: begin
          if (meas.done && in_lock) begin
            state_r <= CLD_LOCKED; // RULE2 RULE9
            lock_ev <= 1'b1;
          end
        end
        CLD_LOCKED: begin
          if ((meas.done && out_lock) || harm_det) begin
            state_r   <= CLD_ACQ; // RULE4 RULE10 RULE14
            lost_ev   <= 1'b1;
            osc_rst_r <= 1'b1; // RULE17
          end
        end
      endcase
    end
  end
  assign meas.start = osc_rst_r;

  // ---------------------------------------------------------------
  // sticky status and pin
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sticky_r   <= 1'b0;
      clr_prev_r <= 1'b0;
    end else begin
      clr_prev_r <= clr_r;
      if (lost_ev) begin
        sticky_r <= 1'b1; // RULE11
      end else if (clr_prev_r && !clr_r) begin
        sticky_r <= 1'b0; // RULE12
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_lost_flag_o <= 1'b1;
      phase_en_o       <= 1'b0;
      osc_reset_o      <= 1'b1;
      div_min_o        <= 1'b1;
    end else begin
      lock_lost_flag_o <= pincfg_r ? (sticky_r || lost_ev) : (state_r == CLD_ACQ); // RULE13
      phase_en_o       <= (state_r == CLD_LOCKED); // RULE3
      osc_reset_o      <= osc_rst_r; // RULE17
      div_min_o        <= osc_rst_r;
    end
  end

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr_mask;
  assign ev       = {harm_det, lock_ev, lost_ev};
  assign clr_mask = (wr && hit(idx, IDX_IRQ_CLR)) ? wb_dat_i[IRQ_W-1:0] : '0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= '0;
      irq_o      <= 1'b0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~clr_mask) | ev;
      irq_o      <= |(irq_stat_r & irq_en_r);
    end
  end

  // ---------------------------------------------------------------
  // wishbone read and ack
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r  <= 1'b0;
      rdat_r <= '0;
    end else begin
      ack_r  <= wb_cyc_i && wb_stb_i && !ack_r;
      rdat_r <= '0;
      unique case (idx)
        IDX_STATUS:   rdat_r[STICKY_BIT] <= sticky_r;
        IDX_MODE:     rdat_r[7:0] <= {1'b0, mode_r, 1'b0, clr_r, 2'b00};
        IDX_PINCFG:   rdat_r[PINCFG_BIT] <= pincfg_r;
        IDX_REFBUF:   rdat_r[7:0] <= {5'h00, pdn_r, 1'b0, fast_r};
        IDX_RATIO:    rdat_r[7:0] <= {2'b00, band_r, ratio_r};
        IDX_IRQ_STAT: rdat_r[IRQ_W-1:0] <= irq_stat_r;
        IDX_IRQ_EN:   rdat_r[IRQ_W-1:0] <= irq_en_r;
        IDX_LIVE:     rdat_r[1:0] <= {phase_en_o, lock_lost_flag_o};
        default:      rdat_r <= '0;
      endcase
    end
  end
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;
endmodule

// *** sim/cld_lock_detector_asserts.sv ***
/*
  cld_lock_detector_asserts: port-level checker for the lock detector.
  assumes: one clock, rst_i synchronous and active high.
*/
module cld_lock_detector_chk
  import cld_pkg::*;
#(
  parameter int GATE  = cld_pkg::GATE_EDGES,
  parameter int HARM  = 1 << cld_pkg::HARM_LOG2,
  parameter int CNT_W = 18
) (
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  input wire logic                       wb_cyc_i,
  input wire logic                       wb_stb_i,
  input wire logic                       wb_we_i,
  input wire logic [cld_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0]                 wb_sel_i,
  input wire logic [31:0]                wb_dat_i,
  input wire logic [31:0]                wb_dat_o,
  input wire logic                       wb_ack_o,
  input wire logic                       osc_edge_i,
  input wire logic                       data_edge_i,
  input wire logic                       ref_edge_i,
  input wire logic                       harm_hit_i,
  input wire logic                       lock_lost_flag_o,
  input wire logic                       phase_en_o,
  input wire logic                       osc_reset_o,
  input wire logic                       div_min_o,
  input wire logic                       irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ---------------------------------------------------------------
  // register port
  // ---------------------------------------------------------------
  ack_one_cycle_a : assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_latency_a : assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered next cycle");
  ack_has_cause_a : assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  irq_mask_off_a : assert property (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o
    && wb_sel_i[0] && wb_adr_i[ADDR_W-1:2] == IDX_IRQ_EN && wb_dat_i[IRQ_W-1:0] == '0
    |-> ##2 !irq_o)
    else $error("irq high with all sources masked");

  // ---------------------------------------------------------------
  // acquisition and lock
  // ---------------------------------------------------------------
  reset_pair_a : assert property (osc_reset_o == div_min_o)
    else $error("oscillator reset and divider reset differ");
  restart_pulse_a : assert property ($rose(osc_reset_o) |-> !phase_en_o ##1 !osc_reset_o)
    else $error("acquisition restart pulse malformed");
  loss_restart_a : assert property ($fell(phase_en_o) |-> ##[0:2] osc_reset_o)
    else $error("lock loss without new acquisition");
  acq_no_phase_a : assert property (osc_reset_o |-> !phase_en_o)
    else $error("phase loop on during acquisition start");
  lock_hold_a : assert property ($rose(phase_en_o) |=> phase_en_o [*8])
    else $error("lock dropped at once");
  loss_hold_a : assert property ($fell(phase_en_o) |=> !phase_en_o [*8])
    else $error("relock without a measurement");
endmodule

bind cld_lock_detector cld_lock_detector_chk #(.GATE(GATE), .HARM(HARM), .CNT_W(CNT_W)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .osc_edge_i(osc_edge_i),
  .data_edge_i(data_edge_i), .ref_edge_i(ref_edge_i), .harm_hit_i(harm_hit_i),
  .lock_lost_flag_o(lock_lost_flag_o), .phase_en_o(phase_en_o),
  .osc_reset_o(osc_reset_o), .div_min_o(div_min_o), .irq_o(irq_o));

// *** sim/cld_edge_src.sv ***
/*
  cld_edge_src: far-side model making the oscillator, data and reference
  edge trains; each line toggles every half_i clock cycles.
  assumes: half periods of 2 or more, so each level lasts at least two clocks.
*/
module cld_edge_src (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [3:0] osc_half_i,
  input  wire logic [3:0] data_half_i,
  input  wire logic [3:0] ref_half_i,
  output logic            osc_o,
  output logic            data_o,
  output logic            ref_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_r [3];
  logic [3:0] half  [3];
  logic [2:0] lvl_r;

  assign half[0] = osc_half_i;
  assign half[1] = data_half_i;
  assign half[2] = ref_half_i;
  assign {ref_o, data_o, osc_o} = lvl_r;

  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 3; i++) begin
      if (rst_i || cnt_r[i] >= half[i] - 4'h1) begin
        cnt_r[i] <= 4'h0;
        lvl_r[i] <= rst_i ? 1'b0 : ~lvl_r[i];
      end else begin
        cnt_r[i] <= cnt_r[i] + 4'h1;
      end
    end
  end
endmodule

// *** sim/test_cld_lock_detector.sv ***
/*
  test_cld_lock_detector: self-checking bench for the lock detector.
  assumes: cld_edge_src drives the edge pins; the checker is bound in.
*/
module test_cld_lock_detector
  import cld_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int GATE_SIM = 4096;
  localparam int HARM_SIM = 16;
  localparam int SLOW     = 50000;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, harm = 1'b0;
  logic [3:0]  sel = 4'hF, osc_h = 4'h2, dat_h = 4'h2, ref_h = 4'h2;
  logic [9:0]  adr = 10'h0;
  logic [31:0] wdat = 32'h0, rdat, dat_o, v;
  logic        ack, lock_lost_flag, phase, osc_rst, dmin, irq, osc_e, dat_e, ref_e;
  int          bad_count = 0, n_tests = 0;
  integer      seed;

  cld_edge_src u_src (.clk_i(clk_i), .rst_i(rst_i), .osc_half_i(osc_h), .data_half_i(dat_h),
    .ref_half_i(ref_h), .osc_o(osc_e), .data_o(dat_e), .ref_o(ref_e));
  cld_lock_detector #(.GATE(GATE_SIM), .HARM(HARM_SIM)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .osc_edge_i(osc_e),
    .data_edge_i(dat_e), .ref_edge_i(ref_e), .harm_hit_i(harm), .lock_lost_flag_o(lock_lost_flag),
    .phase_en_o(phase), .osc_reset_o(osc_rst), .div_min_o(dmin), .irq_o(irq));

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] fld(input int val, input int lsb);
    return 32'(val) << lsb;
  endfunction

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic tmo();
    bad_count++;
    $display("CHECK FAILED at %0t: wait timed out", $time);
    wrap_up();
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // one classic single cycle; read data taken at the ack edge
  task automatic wb(input logic w, input logic [7:0] idx, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'b00};
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) tmo();
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wait_lol(input logic val, input int lim);
    int n;
    n = 0;
    while (lock_lost_flag !== val) begin
      @(posedge clk_i);
      n++;
      if (n > lim) tmo();
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    seed = 32'h77CB;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, IDX_REFBUF, 32'h0);
    chk(rdat, fld(PDN_RST, PDN_BIT) | fld(FAST_RST, FAST_BIT));
    wb(1'b0, IDX_RATIO, 32'h0);
    chk(rdat, fld(BAND_RST, BAND_LSB) | fld(RATIO_RST, RATIO_LSB));
    chk(32'(lock_lost_flag), 32'h1);
    for (int m = 0; m < 8; m++) begin
      wb(1'b1, IDX_MODE, fld(m, MODE_LSB));
      wb(1'b0, IDX_MODE, 32'h0);
      chk(rdat & 32'h70, fld(m, MODE_LSB));
    end
    wb(1'b1, IDX_MODE, 32'h0);
    repeat (3) begin
      v = $random(seed) & 32'h3F;
      wb(1'b1, IDX_RATIO, v);
      wb(1'b0, IDX_RATIO, 32'h0);
      chk(rdat, v);
    end
    wb(1'b1, 8'h30, 32'hFF);
    wb(1'b0, 8'h30, 32'h0);
    chk(rdat, 32'h0);
    // normal lock, then interrupt mask, enable and clear
    wait_lol(1'b0, SLOW);
    repeat (2) @(posedge clk_i);
    chk(32'(phase), 32'h1);
    chk(32'(irq), 32'h0);
    wb(1'b1, IDX_IRQ_EN, 32'h7);
    repeat (2) @(posedge clk_i);
    chk(32'(irq), 32'h1);
    wb(1'b1, IDX_IRQ_CLR, 32'h7);
    repeat (2) @(posedge clk_i);
    chk(32'(irq), 32'h0);
    // harmonic seen while locked
    harm <= 1'b1;
    wait_lol(1'b1, HARM_SIM * 4 + 40);
    harm <= 1'b0;
    wb(1'b0, IDX_IRQ_STAT, 32'h0);
    chk(rdat & fld(1, IRQ_HARM), fld(1, IRQ_HARM));
    wait_lol(1'b0, SLOW);
    wb(1'b0, IDX_STATUS, 32'h0);
    chk(rdat & fld(1, STICKY_BIT), fld(1, STICKY_BIT));
    wb(1'b1, IDX_PINCFG, fld(1, PINCFG_BIT));
    repeat (2) @(posedge clk_i);
    chk(32'(lock_lost_flag), 32'h1);
    wb(1'b1, IDX_MODE, fld(1, CLR_BIT));
    wb(1'b1, IDX_MODE, 32'h0);
    wb(1'b0, IDX_STATUS, 32'h0);
    chk(rdat & fld(1, STICKY_BIT), 32'h0);
    repeat (2) @(posedge clk_i);
    chk(32'(lock_lost_flag), 32'h0);
    // frequency error while locked, pin mirroring the sticky bit
    osc_h <= 4'h3;
    wait_lol(1'b1, SLOW);
    wb(1'b1, IDX_PINCFG, 32'h0);
    chk(32'(phase), 32'h0);
    // lock to the reference while the data rate is wrong
    wb(1'b1, IDX_RATIO, fld(1, BAND_LSB) | fld(6, RATIO_LSB));
    wb(1'b1, IDX_REFBUF, fld(1, FAST_BIT));
    wb(1'b1, IDX_MODE, fld(MODE_LTR, MODE_LSB));
    osc_h <= 4'h2;
    dat_h <= 4'h3;
    wait_lol(1'b0, SLOW);
    harm <= 1'b1;
    repeat (HARM_SIM * 4 + 40) @(posedge clk_i);
    chk(32'(lock_lost_flag), 32'h0);
    harm <= 1'b0;
    osc_h <= 4'h3;
    wait_lol(1'b1, SLOW);
    wb(1'b0, IDX_LIVE, 32'h0);
    chk(32'(rdat[1:0]), 32'h1);
    wb(1'b1, IDX_IRQ_EN, 32'h0);
    repeat (3) @(posedge clk_i);
    chk(32'(irq), 32'h0);
    wrap_up();
  end
endmodule
